/* File: hdl/hpfe_pkg.sv */
/*
 haptic playback front end: shared constants, register indices, field
 positions, reset values and carrier types.
 assumes a 250 MHz core clock and an axi4-lite register port.
*/
package hpfe_pkg;
	// timing
	localparam int unsigned CLK_PS = 4000;
	localparam int unsigned MS_PS = 1000000000;
	localparam int unsigned CYC_PER_MS = MS_PS / CLK_PS;
	localparam int unsigned OL_UNIT_PS = 98490000;
	localparam int unsigned CYC_PER_OL_HALF = OL_UNIT_PS / (2 * CLK_PS);
	localparam int unsigned WAIT_MS_LSB = 10;
	localparam logic [2:0] STEP_MS_SLOW = 3'h5;
	localparam logic [2:0] STEP_MS_FAST = 3'h1;
	localparam int unsigned DUTY_WIN_BITS = 16;
	localparam logic [6:0] PWM_DIV_LAST = 7'h7f;
	// register indices, byte address is four times the index
	localparam int ADDR_W = 8;
	localparam logic [5:0] REG_STATUS = 6'h00;
	localparam logic [5:0] REG_MODE = 6'h01;
	localparam logic [5:0] REG_RTP = 6'h02;
	localparam logic [5:0] REG_LIB = 6'h03;
	localparam logic [5:0] REG_SEQ0 = 6'h04;
	localparam logic [5:0] REG_SEQ7 = 6'h0b;
	localparam logic [5:0] REG_GO = 6'h0c;
	localparam logic [5:0] REG_ODT = 6'h0d;
	localparam logic [5:0] REG_SPT = 6'h0e;
	localparam logic [5:0] REG_SNT = 6'h0f;
	localparam logic [5:0] REG_BRT = 6'h10;
	localparam logic [5:0] REG_CLAMP = 6'h17;
	localparam logic [5:0] REG_LOOP = 6'h1d;
	localparam logic [5:0] REG_CTRL = 6'h1f;
	localparam logic [5:0] REG_OLP = 6'h20;
	localparam logic [5:0] REG_NONE = 6'h3f;
	// field positions
	localparam int MODE_STANDBY_BIT = 6;
	localparam int LOOP_OPEN_BIT = 0;
	localparam int LOOP_NG_LSB = 2;
	localparam int CTRL_PB_INT_BIT = 0;
	localparam int SEQ_WAIT_BIT = 7;
	localparam logic [2:0] LIB_CLOSED = 3'h6;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h40;
	localparam logic [7:0] LIB_RST = 8'h01;
	localparam logic [7:0] CLAMP_RST = 8'h8c;
	localparam logic [7:0] LOOP_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OLP_RST = 8'h33;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_INT_TRIG, MODE_EDGE_TRIG, MODE_LEVEL_TRIG, MODE_PWM,
		MODE_AUDIO, MODE_RTP, MODE_DIAG, MODE_CAL
	} hpfe_mode_t;
	typedef enum logic [1:0] {SEG_OVERDRIVE, SEG_SUST_POS, SEG_SUST_NEG, SEG_BRAKE} hpfe_seg_t;
	typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_PLAY, SQ_WAIT} hpfe_seq_t;

	typedef struct packed {
		logic [7:0] od;
		logic [7:0] sp;
		logic [7:0] sn;
		logic [7:0] br;
	} hpfe_offs_t;

	typedef struct packed {
		logic level;
		logic rise;
		logic [7:0] duty;
		logic div_pol;
	} hpfe_pin_t;

	// noise gate threshold by 2-bit setting
	function automatic logic [7:0] hpfe_ng_level(input logic [1:0] sel);
		case (sel)
			2'h0: hpfe_ng_level = 8'h00;
			2'h1: hpfe_ng_level = 8'h0a;
			2'h2: hpfe_ng_level = 8'h14;
			default: hpfe_ng_level = 8'h29;
		endcase
	endfunction
endpackage

/* File: hdl/hpfe_timebase.sv */
/*
 millisecond tick and open-loop half-period unit tick.
 assumes one core clock; ticks are one-cycle enables.
*/
`timescale 1ns/100ps
`default_nettype none
module hpfe_timebase
	import hpfe_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS,
	parameter int unsigned CYC_HALF = CYC_PER_OL_HALF
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	output logic ms_tick_o,
	output logic half_tick_o
);
	localparam int MS_W = $clog2(CYC_MS);
	localparam int HF_W = $clog2(CYC_HALF);
	logic [MS_W-1:0] ms_cnt_q;
	logic [HF_W-1:0] hf_cnt_q;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ms_cnt_q <= '0;
			ms_tick_o <= 1'b0;
		end
		else
		begin
			ms_tick_o <= (ms_cnt_q == MS_W'(CYC_MS - 1));
			ms_cnt_q <= (ms_cnt_q == MS_W'(CYC_MS - 1)) ? '0 : ms_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hf_cnt_q <= '0;
			half_tick_o <= 1'b0;
		end
		else
		begin
			half_tick_o <= (hf_cnt_q == HF_W'(CYC_HALF - 1));
			hf_cnt_q <= (hf_cnt_q == HF_W'(CYC_HALF - 1)) ? '0 : hf_cnt_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/hpfe_pin_meter.sv */
/*
 input pin front end: two-stage synchroniser, rising edge, duty measure
 over a fixed window and a polarity that flips every 128 input pulses.
 assumes the pin is asynchronous to the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module hpfe_pin_meter
	import hpfe_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pin_i,
	output var hpfe_pin_t pin_o
);
	logic sync1_q;
	logic sync2_q;
	logic last_q;
	logic rise_q;
	logic [DUTY_WIN_BITS-1:0] win_q;
	logic [DUTY_WIN_BITS-1:0] high_q;
	logic [7:0] duty_q;
	logic [6:0] rise_cnt_q;
	logic pol_q;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else
		begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			last_q <= sync2_q;
			rise_q <= sync2_q & ~last_q;
		end
	end

	// high samples over one window give the duty
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			win_q <= '0;
			high_q <= '0;
			duty_q <= 8'h00;
		end
		else
		begin
			win_q <= win_q + 1'b1;
			if (&win_q)
			begin
				duty_q <= high_q[DUTY_WIN_BITS-1 -: 8];
				high_q <= '0;
			end
			else
			begin
				high_q <= high_q + DUTY_WIN_BITS'(last_q);
			end
		end
	end

	// fixed divide by 128 of the pulse train
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rise_cnt_q <= 7'h00;
			pol_q <= 1'b0;
		end
		else if (rise_q)
		begin
			rise_cnt_q <= rise_cnt_q + 1'b1;
			if (rise_cnt_q == PWM_DIV_LAST)
			begin
				pol_q <= ~pol_q;
			end
		end
	end

	assign pin_o = '{level: last_q, rise: rise_q, duty: duty_q, div_pol: pol_q};
endmodule
`default_nettype wire

/* File: hdl/hpfe_top.sv */
/*
 haptic playback front end: axi4-lite register file, mode decode,
 trigger handling, eight-slot sequencer, time-offset stretching and
 drive level / polarity selection.
 assumes a rom playback engine and resonance tracker outside that take
 effect_start_o / effect_id_o and report effect_done_i / track_polarity_i.
*/
`timescale 1ns/100ps
`default_nettype none
module hpfe_top
	import hpfe_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS,
	parameter int unsigned CYC_HALF = CYC_PER_OL_HALF
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic input_trigger_pin_i,
	input wire logic effect_done_i,
	input wire logic track_polarity_i,
	input wire hpfe_seg_t segment_kind_i,
	input wire logic [7:0] segment_time_i,
	output logic [7:0] drive_level_o,
	output logic drive_polarity_o,
	output logic drive_active_o,
	output logic effect_start_o,
	output logic [6:0] effect_id_o,
	output logic [2:0] library_sel_o,
	output logic library_closed_loop_o,
	output logic step_tick_o,
	output logic [7:0] segment_time_o
);
	function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = (a[1:0] == 2'h0) ? a[ADDR_W-1:2] : REG_NONE;
	endfunction

	function automatic logic is_mapped(input logic [5:0] i);
		is_mapped = (i <= REG_BRT) || (i == REG_CLAMP) || (i == REG_LOOP)
			|| (i == REG_CTRL) || (i == REG_OLP);
	endfunction

	logic [7:0] mode_q, rtp_q, lib_q, clamp_q, loop_q, ctrl_q, olp_q;
	logic [7:0] seq_q [8];
	hpfe_offs_t offs_q;
	logic go_q;
	hpfe_seq_t state_q;
	logic [2:0] slot_q;
	logic [10:0] wait_q;
	logic [2:0] step_cnt_q;
	logic [6:0] ol_cnt_q;
	logic ol_pol_q;
	logic aw_hold_q, w_hold_q;
	logic [5:0] aw_idx_q;
	logic [7:0] w_data_q;
	logic w_en_q;
	logic ms_tick, half_tick;
	hpfe_pin_t pin;

	hpfe_timebase #(.CYC_MS(CYC_MS), .CYC_HALF(CYC_HALF)) i_hpfe_timebase (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ms_tick_o(ms_tick),
		.half_tick_o(half_tick)
	);

	hpfe_pin_meter i_hpfe_pin_meter (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.pin_i(input_trigger_pin_i),
		.pin_o(pin)
	);

	// decoded controls
	hpfe_mode_t mode;
	logic standby, open_loop, continuous, rom_active, seq_mode;
	assign mode = hpfe_mode_t'(mode_q[2:0]);
	assign standby = mode_q[MODE_STANDBY_BIT];
	assign open_loop = loop_q[LOOP_OPEN_BIT];
	assign continuous = ~standby & ((mode == MODE_PWM) | (mode == MODE_RTP));
	assign rom_active = (state_q == SQ_PLAY);
	assign seq_mode = (mode != MODE_AUDIO) & (mode != MODE_DIAG) & (mode != MODE_CAL);

	// axi write channel
	logic aw_take, w_take, wr_do, aw_hold_d, w_hold_d, bvalid_d;
	logic wr_hit;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_do = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign aw_hold_d = (aw_hold_q | aw_take) & ~wr_do;
	assign w_hold_d = (w_hold_q | w_take) & ~wr_do;
	assign bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);
	assign wr_hit = wr_do & w_en_q & is_mapped(aw_idx_q);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_idx_q <= REG_NONE;
			w_data_q <= 8'h00;
			w_en_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			if (aw_take)
			begin
				aw_idx_q <= reg_index(s_axi_awaddr);
			end
			if (w_take)
			begin
				w_data_q <= s_axi_wdata[7:0];
				w_en_q <= s_axi_wstrb[0];
			end
			s_axi_awready <= ~aw_hold_d & ~bvalid_d;
			s_axi_wready <= ~w_hold_d & ~bvalid_d;
			s_axi_bvalid <= bvalid_d;
			if (wr_do)
			begin
				s_axi_bresp <= is_mapped(aw_idx_q) ? AXI_OKAY : AXI_SLVERR;
			end
		end
	end

	// register file
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mode_q <= MODE_RST;
			rtp_q <= ZERO8;
			lib_q <= LIB_RST;
			clamp_q <= CLAMP_RST;
			loop_q <= LOOP_RST;
			ctrl_q <= CTRL_RST;
			olp_q <= OLP_RST;
			offs_q <= '0;
			for (int i = 0; i < 8; i++)
			begin
				seq_q[i] <= ZERO8;
			end
		end
		else if (wr_hit)
		begin
			if (aw_idx_q == REG_MODE)
				mode_q <= w_data_q;
			else if (aw_idx_q == REG_RTP)
				rtp_q <= w_data_q;
			else if (aw_idx_q == REG_LIB)
				lib_q <= w_data_q;
			else if (aw_idx_q >= REG_SEQ0 && aw_idx_q <= REG_SEQ7)
				seq_q[3'(aw_idx_q - REG_SEQ0)] <= w_data_q;
			else if (aw_idx_q == REG_ODT)
				offs_q.od <= w_data_q;
			else if (aw_idx_q == REG_SPT)
				offs_q.sp <= w_data_q;
			else if (aw_idx_q == REG_SNT)
				offs_q.sn <= w_data_q;
			else if (aw_idx_q == REG_BRT)
				offs_q.br <= w_data_q;
			else if (aw_idx_q == REG_CLAMP)
				clamp_q <= w_data_q;
			else if (aw_idx_q == REG_LOOP)
				loop_q <= w_data_q;
			else if (aw_idx_q == REG_CTRL)
				ctrl_q <= w_data_q;
			else if (aw_idx_q == REG_OLP)
				olp_q <= w_data_q;
		end
	end

	// read channel
	logic ar_take;
	logic [5:0] ar_idx;
	logic [7:0] rd_val;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign ar_idx = reg_index(s_axi_araddr);

	always_comb
	begin
		rd_val = ZERO8;
		if (ar_idx == REG_STATUS)
			rd_val = {pin.level, 1'b0, state_q, go_q, slot_q};
		else if (ar_idx == REG_MODE)
			rd_val = mode_q;
		else if (ar_idx == REG_RTP)
			rd_val = rtp_q;
		else if (ar_idx == REG_LIB)
			rd_val = lib_q;
		else if (ar_idx >= REG_SEQ0 && ar_idx <= REG_SEQ7)
			rd_val = seq_q[3'(ar_idx - REG_SEQ0)];
		else if (ar_idx == REG_GO)
			rd_val = {7'h00, go_q};
		else if (ar_idx == REG_ODT)
			rd_val = offs_q.od;
		else if (ar_idx == REG_SPT)
			rd_val = offs_q.sp;
		else if (ar_idx == REG_SNT)
			rd_val = offs_q.sn;
		else if (ar_idx == REG_BRT)
			rd_val = offs_q.br;
		else if (ar_idx == REG_CLAMP)
			rd_val = clamp_q;
		else if (ar_idx == REG_LOOP)
			rd_val = loop_q;
		else if (ar_idx == REG_CTRL)
			rd_val = ctrl_q;
		else if (ar_idx == REG_OLP)
			rd_val = olp_q;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end
		else
		begin
			s_axi_arready <= ~ar_take & ~(s_axi_rvalid & ~s_axi_rready);
			if (ar_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_val};
				s_axi_rresp <= is_mapped(ar_idx) ? AXI_OKAY : AXI_SLVERR;
			end
			else if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// start bit: software, pin triggers, sequencer end
	logic sw_go_wr, go_set, go_clr, seq_end, pin_edge_mode;
	assign sw_go_wr = wr_hit & (aw_idx_q == REG_GO);
	assign pin_edge_mode = (mode == MODE_EDGE_TRIG) | (mode == MODE_RTP);
	assign go_set = (sw_go_wr & w_data_q[0]) | (pin_edge_mode & pin.rise & ~go_q);
	assign go_clr = (sw_go_wr & ~w_data_q[0]) | (pin_edge_mode & pin.rise & go_q) | seq_end;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			go_q <= 1'b0;
		else if (standby)
			go_q <= 1'b0;
		else if (mode == MODE_LEVEL_TRIG)
			go_q <= pin.level;
		else if (go_set)
			go_q <= 1'b1;
		else if (go_clr)
			go_q <= 1'b0;
	end

	// waveform sequencer
	logic [7:0] entry;
	logic last_slot;
	assign entry = seq_q[slot_q];
	assign last_slot = (slot_q == 3'h7);
	assign seq_end = ((state_q == SQ_FETCH) & (entry == ZERO8))
		| (((state_q == SQ_PLAY) & effect_done_i) & last_slot)
		| (((state_q == SQ_WAIT) & (wait_q == 11'h000) & ms_tick) & last_slot);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= SQ_IDLE;
			slot_q <= 3'h0;
			wait_q <= 11'h000;
			effect_start_o <= 1'b0;
			effect_id_o <= 7'h00;
		end
		else
		begin
			effect_start_o <= 1'b0;
			if (!go_q || standby || !seq_mode)
			begin
				state_q <= SQ_IDLE;
				slot_q <= 3'h0;
			end
			else
			begin
				case (state_q)
					SQ_IDLE:
						state_q <= SQ_FETCH;
					SQ_FETCH:
						if (entry == ZERO8)
							state_q <= SQ_IDLE;
						else if (entry[SEQ_WAIT_BIT])
						begin
							wait_q <= 11'(entry[6:0] * WAIT_MS_LSB);
							state_q <= SQ_WAIT;
						end
						else
						begin
							effect_id_o <= entry[6:0];
							effect_start_o <= 1'b1;
							state_q <= SQ_PLAY;
						end
					SQ_PLAY:
						if (effect_done_i)
						begin
							state_q <= last_slot ? SQ_IDLE : SQ_FETCH;
							slot_q <= slot_q + 1'b1;
						end
					default:
						if (ms_tick && wait_q == 11'h000)
						begin
							state_q <= last_slot ? SQ_IDLE : SQ_FETCH;
							slot_q <= slot_q + 1'b1;
						end
						else if (ms_tick)
							wait_q <= wait_q - 1'b1;
				endcase
			end
		end
	end

	// rom step timebase
	logic [2:0] step_len;
	assign step_len = ctrl_q[CTRL_PB_INT_BIT] ? STEP_MS_FAST : STEP_MS_SLOW;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			step_cnt_q <= 3'h0;
			step_tick_o <= 1'b0;
		end
		else
		begin
			step_tick_o <= 1'b0;
			if (!rom_active)
				step_cnt_q <= 3'h0;
			else if (ms_tick)
			begin
				if (step_cnt_q >= step_len - 1'b1)
				begin
					step_cnt_q <= 3'h0;
					step_tick_o <= 1'b1;
				end
				else
					step_cnt_q <= step_cnt_q + 1'b1;
			end
		end
	end

	// segment time stretching
	logic [7:0] offs_sel;
	logic signed [9:0] seg_sum;
	always_comb
	begin
		case (segment_kind_i)
			SEG_OVERDRIVE: offs_sel = offs_q.od;
			SEG_SUST_POS: offs_sel = offs_q.sp;
			SEG_SUST_NEG: offs_sel = offs_q.sn;
			default: offs_sel = offs_q.br;
		endcase
	end
	assign seg_sum = $signed({2'b00, segment_time_i}) + $signed({{2{offs_sel[7]}}, offs_sel});

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			segment_time_o <= 8'h00;
		else if (!rom_active)
			segment_time_o <= segment_time_i;
		else if (seg_sum < 0)
			segment_time_o <= 8'h00;
		else if (seg_sum > 10'sd255)
			segment_time_o <= 8'hff;
		else
			segment_time_o <= seg_sum[7:0];
	end

	// digital open-loop resonant period
	logic [6:0] ol_period;
	assign ol_period = (olp_q[6:0] == 7'h00) ? 7'h01 : olp_q[6:0];

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ol_cnt_q <= 7'h00;
			ol_pol_q <= 1'b0;
		end
		else if (half_tick)
		begin
			if (ol_cnt_q >= ol_period - 1'b1)
			begin
				ol_cnt_q <= 7'h00;
				ol_pol_q <= ~ol_pol_q;
			end
			else
				ol_cnt_q <= ol_cnt_q + 1'b1;
		end
	end

	// drive selection
	logic [15:0] pwm_scaled;
	logic [7:0] pwm_level;
	assign pwm_scaled = pin.duty * clamp_q + 16'(clamp_q);
	assign pwm_level = (pwm_scaled[15:8] < hpfe_ng_level(loop_q[LOOP_NG_LSB +: 2])) ?
		8'h00 : pwm_scaled[15:8];

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			drive_level_o <= 8'h00;
			drive_polarity_o <= 1'b0;
			drive_active_o <= 1'b0;
			library_sel_o <= 3'h0;
			library_closed_loop_o <= 1'b0;
		end
		else
		begin
			drive_active_o <= continuous | (rom_active & ~standby);
			if (!continuous)
				drive_level_o <= 8'h00;
			else if (mode == MODE_PWM)
				drive_level_o <= pwm_level;
			else
				drive_level_o <= rtp_q;
			if (!open_loop)
				drive_polarity_o <= track_polarity_i;
			else if (continuous && mode == MODE_PWM)
				drive_polarity_o <= pin.div_pol;
			else
				drive_polarity_o <= ol_pol_q;
			library_sel_o <= lib_q[2:0];
			library_closed_loop_o <= (lib_q[2:0] == LIB_CLOSED);
		end
	end
endmodule
`default_nettype wire

/* File: sim/hpfe_rom_model.sv */
/*
 playback engine stand-in: answers each effect start with a done pulse.
 assumes the block's clock; slow_i picks a long effect.
*/
`timescale 1ns/100ps
`default_nettype none
module hpfe_rom_model
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic slow_i,
	output logic done_o
);
	int cnt_q;
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			cnt_q <= 0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= (cnt_q == 1);
			if (start_i)
				cnt_q <= slow_i ? 3000 : 20;
			else if (cnt_q != 0)
				cnt_q <= cnt_q - 1;
		end
endmodule
`default_nettype wire

/* File: sim/hpfe_top_sva.sv */
/*
 checker for the playback front end.
 assumes it is bound to hpfe_top and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module hpfe_top_sva
	import hpfe_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic effect_start_o,
	input wire logic [6:0] effect_id_o,
	input wire logic [2:0] library_sel_o,
	input wire logic library_closed_loop_o,
	input wire logic step_tick_o,
	input wire logic [7:0] drive_level_o,
	input wire logic drive_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_lib;
		library_closed_loop_o == (library_sel_o == LIB_CLOSED);
	endproperty
	a_lib: assert property (p_lib) else $error("closed-loop flag wrong");
	property p_start;
		effect_start_o |=> !effect_start_o;
	endproperty
	a_start: assert property (p_start) else $error("start not a pulse");
	property p_id;
		effect_start_o |-> effect_id_o != 7'h00;
	endproperty
	a_id: assert property (p_id) else $error("zero effect launched");
	property p_step;
		step_tick_o |=> !step_tick_o [*8];
	endproperty
	a_step: assert property (p_step) else $error("step ticks too close");
	property p_idle;
		!drive_active_o |-> drive_level_o == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("level while idle");
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	c_start: cover property (effect_start_o);
	c_step: cover property (step_tick_o);
	c_act: cover property (drive_active_o);
endmodule
bind hpfe_top hpfe_top_sva i_hpfe_top_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.effect_start_o(effect_start_o), .effect_id_o(effect_id_o),
	.library_sel_o(library_sel_o), .library_closed_loop_o(library_closed_loop_o),
	.step_tick_o(step_tick_o), .drive_level_o(drive_level_o),
	.drive_active_o(drive_active_o));
`default_nettype wire

/* File: sim/hpfe_top_tb.sv */
/*
 self-checking bench for the playback front end.
 assumes short ms count (50 cycles) and the playback engine model.
*/
`timescale 1ns/100ps
`default_nettype none
module hpfe_top_tb
	import hpfe_pkg::*;
;
	localparam int MS = 50;
	logic clk_i = 0, rst_b_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic rready = 0, pin = 0, slow = 0, done, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 0, araddr = 0, stime = 0, lvl, sto;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	hpfe_seg_t kind = SEG_OVERDRIVE;
	logic pol, act, est, stick, lcl;
	logic [6:0] eid;
	logic [2:0] lsel;
	int bad_count = 0, n_tests = 0;
	logic [6:0] ids[$];
	time ts[$];
	hpfe_top #(.CYC_MS(MS), .CYC_HALF(10)) i_hpfe_top (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.input_trigger_pin_i(pin), .effect_done_i(done), .track_polarity_i(1'b0),
		.segment_kind_i(kind), .segment_time_i(stime), .drive_level_o(lvl),
		.drive_polarity_o(pol), .drive_active_o(act), .effect_start_o(est),
		.effect_id_o(eid), .library_sel_o(lsel), .library_closed_loop_o(lcl),
		.step_tick_o(stick), .segment_time_o(sto));
	hpfe_rom_model i_hpfe_rom_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(est),
		.slow_i(slow), .done_o(done));
	initial forever #2 clk_i = ~clk_i;
	always @(negedge clk_i)
		if (est === 1'b1)
		begin
			ids.push_back(eid);
			ts.push_back($time);
		end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		int n;
		logic ta, tw, tb;
		n = 0;
		tb = 0;
		@(posedge clk_i);
		awaddr <= {a, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb)
		begin
			@(negedge clk_i);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			@(posedge clk_i);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			n++;
			if (n > 200)
				chk(32'h0, 32'h1);
			if (n > 200)
				wrap_up;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tr;
		n = 0;
		tr = 0;
		@(posedge clk_i);
		araddr <= {a, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr)
		begin
			@(negedge clk_i);
			ta = arvalid & arready;
			tr = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (ta)
				arvalid <= 1'b0;
			n++;
			if (n > 200)
				chk(32'h0, 32'h1);
			if (n > 200)
				wrap_up;
		end
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [5:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, {24'h0, e});
	endtask
	task automatic gap(output int g);
		int n;
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (stick !== 1'b1 && n < 2000);
		g = 0;
		do
		begin
			@(negedge clk_i);
			g++;
		end
		while (stick !== 1'b1 && g < 2000);
	endtask
	task automatic pulse;
		@(posedge clk_i);
		pin <= 1'b1;
		tick(300);
		pin <= 1'b0;
		tick(10);
	endtask
	task automatic flips(input bit tog, output int d);
		int t0, t1;
		logic v;
		t0 = 0;
		t1 = 0;
		@(negedge clk_i);
		v = pol;
		for (int c = 1; c <= 6000; c++)
		begin
			@(posedge clk_i);
			if (tog && c % 8 == 0)
				pin <= ~pin;
			@(negedge clk_i);
			if (pol !== v)
			begin
				v = pol;
				t0 = t1;
				t1 = c;
			end
		end
		d = t1 - t0;
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rc(REG_MODE, MODE_RST);
		rc(REG_CLAMP, CLAMP_RST);
		rc(REG_OLP, OLP_RST);
		rc(REG_ODT, ZERO8);
		rd(REG_NONE, d, r);
		chk({30'h0, r}, {30'h0, AXI_SLVERR});
		wr(REG_LIB, 8'h06);
		tick(2);
		chk({28'h0, lcl, lsel}, 32'he);
		wr(REG_LIB, 8'h02);
		tick(2);
		chk({28'h0, lcl, lsel}, 32'h2);
		$display("registers done");
	endtask
	task automatic t_seq;
		int n;
		logic [31:0] d;
		logic [1:0] r;
		wr(REG_SEQ0, 8'h05);
		wr(REG_SEQ0 + 6'h1, 8'h81);
		wr(REG_SEQ0 + 6'h2, 8'h09);
		wr(REG_MODE, 8'h00);
		wr(REG_GO, 8'h01);
		n = 0;
		do
		begin
			tick(20);
			rd(REG_GO, d, r);
			n++;
		end
		while (d[0] !== 1'b0 && n < 100);
		chk(d, 32'h0);
		chk(ids.size(), 2);
		chk({25'h0, ids[0]}, 32'h5);
		chk({25'h0, ids[1]}, 32'h9);
		chk({31'h0, ts[1] - ts[0] >= 2000 && ts[1] - ts[0] < 2400}, 32'h1);
		$display("sequence done");
	endtask
	task automatic t_step;
		int g;
		slow <= 1'b1;
		kind <= SEG_BRAKE;
		stime <= 8'h10;
		wr(REG_SEQ0 + 6'h1, 8'h00);
		wr(REG_BRT, 8'hfc);
		tick(3);
		chk(sto, 8'h10);
		wr(REG_GO, 8'h01);
		gap(g);
		chk(g, 5 * MS);
		chk(sto, 8'h0c);
		wr(REG_CTRL, 8'h01);
		gap(g);
		gap(g);
		chk(g, MS);
		wr(REG_GO, 8'h00);
		rc(REG_GO, 8'h00);
		wr(REG_GO, 8'h01);
		tick(20);
		wr(REG_MODE, MODE_RST);
		rc(REG_GO, 8'h00);
		$display("step and offsets done");
	endtask
	task automatic t_trig;
		wr(REG_MODE, 8'h01);
		pulse;
		rc(REG_GO, 8'h01);
		pulse;
		rc(REG_GO, 8'h00);
		wr(REG_MODE, 8'h02);
		pin <= 1'b1;
		tick(10);
		rc(REG_GO, 8'h01);
		pin <= 1'b0;
		tick(10);
		rc(REG_GO, 8'h00);
		wr(REG_RTP, 8'h80);
		wr(REG_MODE, 8'h05);
		tick(3);
		chk(act, 1);
		chk(lvl, 8'h80);
		wr(REG_MODE, MODE_RST);
		tick(3);
		chk(act, 0);
		$display("triggers done");
	endtask
	task automatic t_pwm;
		int d;
		wr(REG_LOOP, 8'h01);
		wr(REG_MODE, 8'h03);
		tick(3);
		chk(act, 1);
		flips(1, d);
		chk(d, 128 * 16);
		wr(REG_MODE, 8'h05);
		flips(0, d);
		chk(d, OLP_RST[6:0] * 10);
		wr(REG_MODE, MODE_RST);
		$display("open loop done");
	endtask
	initial
	begin
		tick(5);
		rst_b_i <= 1'b1;
		tick(2);
		t_regs;
		t_seq;
		t_step;
		t_trig;
		t_pwm;
		wrap_up;
	end
endmodule
`default_nettype wire
